/* File: rtl/cell_open_wire_diagnostic.sv */
// Per-channel cell wiring diagnostic with register port and interrupt
//Contract
//RL1 - Scan installed channels only while out of lockout and with contactors closed.
//RL2 - Report wiring faults through one flag per cell.
//RL3 - A disable setting of 1 suppresses all fault reporting, default 0.
//RL4 - Start a full scan once per configurable period, default 360000000.
//RL5 - Run periodic scans only while the batteries are connected to the DC bus.
//RL6 - Set a cell flag only once its detection count reaches the threshold, default 3.
//RL7 - Each channel counter saturates at the configured maximum count.
//RL8 - One evaluation gathers samples over max-count measurement scan cycles.
//RL9 - Software keeps the maximum count no lower than the threshold, default 10.
//RL10 - A ratio below the lower bound, default 800 of 1000, is a detection.
//RL11 - A ratio above the upper bound, default 970 of 1000, is a detection.
//RL12 - A clean sample decrements the counter down to zero and the flag clears below threshold.
`timescale 1ns/1ns
`default_nettype none
module cell_open_wire_diagnostic
  import owd_pkg::*;
(
  // Clock and reset
  input  wire logic              clock_in,
  input  wire logic              sys_rst_in,
  // Register port
  input  wire reg_req_t          reg_req_in,
  output logic [31:0]            reg_rdata_out,
  // System state pins
  input  wire logic              lockout_in,
  input  wire logic              contactors_closed_in,
  input  wire logic              bus_connected_in,
  input  wire logic [CH_N-1:0]   chan_installed_in,
  // Measurement front end
  input  wire logic              meas_scan_done_in,
  input  wire logic              sample_valid_in,
  input  wire sample_t           sample_in,
  // Results
  output logic [CH_N-1:0]        open_wire_out,
  output logic                   scan_active_out,
  output logic                   irq_out
);

  // Synchronisers for pin inputs
  logic [2:0] pins_s1_q;
  logic [2:0] pins_s2_q;
  logic [CH_N-1:0] inst_s1_q;
  logic [CH_N-1:0] inst_s2_q;

  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      pins_s1_q <= 3'h0;
      pins_s2_q <= 3'h0;
      inst_s1_q <= '0;
      inst_s2_q <= '0;
    end
    else
    begin
      pins_s1_q <= {lockout_in, contactors_closed_in, bus_connected_in};
      pins_s2_q <= pins_s1_q;
      inst_s1_q <= chan_installed_in;
      inst_s2_q <= inst_s1_q;
    end
  end

  logic scan_allowed;
  assign scan_allowed = !pins_s2_q[2] && pins_s2_q[1] && pins_s2_q[0]; // [RL1] [RL5]

  // Configuration registers
  logic                disable_q;
  logic [31:0]         period_q;
  logic [CNT_W-1:0]    thresh_q;
  logic [CNT_W-1:0]    max_q;
  logic [RATIO_W-1:0]  lower_q;
  logic [RATIO_W-1:0]  upper_q;
  logic [IRQ_W-1:0]    ien_q;

  logic wr_ok;
  assign wr_ok = reg_req_in.wr;

  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      disable_q <= RST_DISABLE;
      period_q  <= RST_PERIOD;
      thresh_q  <= RST_THRESH;
      max_q     <= RST_MAX;
      lower_q   <= RST_LOWER;
      upper_q   <= RST_UPPER;
      ien_q     <= '0;
    end
    else if (wr_ok)
    begin
      case (reg_req_in.addr)
        ADDR_CTRL:   disable_q <= reg_req_in.wdata[CTRL_DIS_BIT];
        ADDR_PERIOD: period_q  <= reg_req_in.wdata;
        ADDR_THRESH: thresh_q  <= reg_req_in.wdata[CNT_W-1:0];
        ADDR_MAX:    max_q     <= reg_req_in.wdata[CNT_W-1:0];
        ADDR_LOWER:  lower_q   <= reg_req_in.wdata[RATIO_W-1:0];
        ADDR_UPPER:  upper_q   <= reg_req_in.wdata[RATIO_W-1:0];
        ADDR_IEN:    ien_q     <= reg_req_in.wdata[IRQ_W-1:0];
        default:     ;
      endcase
    end
  end

  // Period timer and scan sequencer
  scan_state_t      state_q;
  logic [31:0]      tick_q;
  logic [CNT_W-1:0] cycles_q;
  logic             scan_start;
  logic             scan_end;

  assign scan_start = (state_q == ST_IDLE) && scan_allowed && (tick_q >= period_q); // [RL4]
  assign scan_end   = (state_q == ST_RUN) && meas_scan_done_in
                      && (cycles_q + 8'h01 >= max_q); // [RL8]

  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      tick_q <= 32'h0000_0000;
    end
    else if (!scan_allowed || scan_start)
    begin
      tick_q <= 32'h0000_0000; // [RL5]
    end
    else if (tick_q < period_q)
    begin
      tick_q <= tick_q + 32'h0000_0001; // [RL4]
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      state_q  <= ST_IDLE;
      cycles_q <= '0;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          cycles_q <= '0;
          if (scan_start)
          begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN:
        begin
          if (!scan_allowed || scan_end)
          begin
            state_q <= ST_IDLE; // [RL1]
          end
          else if (meas_scan_done_in)
          begin
            cycles_q <= cycles_q + 8'h01; // [RL8]
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Sample qualification
  logic sample_take;
  logic sample_bad;
  assign sample_take = (state_q == ST_RUN) && scan_allowed && sample_valid_in;
  assign sample_bad  = (sample_in.ratio < lower_q)   // [RL10]
                     || (sample_in.ratio > upper_q); // [RL11]

  // Per-channel counters and flags
  logic [CNT_W-1:0] cnt_q [CH_N];
  logic [CH_N-1:0]  flag_q;
  logic [CH_N-1:0]  flag_rise;

  genvar g;
  generate
    for (g = 0; g < CH_N; g++)
    begin : g_chan
      logic hit;
      logic [CNT_W-1:0] cnt_d;
      assign hit = sample_take && (sample_in.chan == 4'(g)) && inst_s2_q[g];

      always_comb
      begin
        cnt_d = cnt_q[g];
        if (hit && sample_bad)
        begin
          if (cnt_q[g] < max_q)
          begin
            cnt_d = cnt_q[g] + 8'h01; // [RL7]
          end
          else
          begin
            cnt_d = max_q; // [RL7]
          end
        end
        else if (hit && cnt_q[g] != 8'h00)
        begin
          cnt_d = cnt_q[g] - 8'h01; // [RL12]
        end
      end

      always_ff @(posedge clock_in)
      begin
        if (sys_rst_in)
        begin
          cnt_q[g]  <= '0;
          flag_q[g] <= 1'b0;
        end
        else
        begin
          cnt_q[g]  <= cnt_d;
          flag_q[g] <= (cnt_d >= thresh_q) && (thresh_q != 8'h00); // [RL6] [RL12]
        end
      end

      assign flag_rise[g] = (cnt_d >= thresh_q) && (thresh_q != 8'h00) && !flag_q[g];
    end
  endgenerate

  // Interrupt status, set wins over clear
  logic [IRQ_W-1:0] istat_q;
  logic [IRQ_W-1:0] ev;
  logic [IRQ_W-1:0] clr;
  assign ev[IRQ_SET_BIT]  = |flag_rise && !disable_q;
  assign ev[IRQ_DONE_BIT] = scan_end;
  assign clr = (wr_ok && reg_req_in.addr == ADDR_ICLR) ? reg_req_in.wdata[IRQ_W-1:0] : '0;

  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      istat_q <= '0;
    end
    else
    begin
      istat_q <= (istat_q & ~clr) | ev;
    end
  end

  // Outputs
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      open_wire_out   <= '0;
      scan_active_out <= 1'b0;
      irq_out         <= 1'b0;
    end
    else
    begin
      open_wire_out   <= disable_q ? '0 : flag_q; // [RL2] [RL3]
      scan_active_out <= (state_q == ST_RUN);
      irq_out         <= |(((istat_q & ~clr) | ev) & ien_q);
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      reg_rdata_out <= 32'h0000_0000;
    end
    else if (reg_req_in.rd)
    begin
      case (reg_req_in.addr)
        ADDR_CTRL:   reg_rdata_out <= {31'h0, disable_q};
        ADDR_PERIOD: reg_rdata_out <= period_q;
        ADDR_THRESH: reg_rdata_out <= {24'h00_0000, thresh_q};
        ADDR_MAX:    reg_rdata_out <= {24'h00_0000, max_q};
        ADDR_LOWER:  reg_rdata_out <= {22'h0, lower_q};
        ADDR_UPPER:  reg_rdata_out <= {22'h0, upper_q};
        ADDR_FLAGS:  reg_rdata_out <= {16'h0000, disable_q ? 16'h0000 : flag_q}; // [RL3]
        ADDR_ISTAT:  reg_rdata_out <= {30'h0, istat_q};
        ADDR_IEN:    reg_rdata_out <= {30'h0, ien_q};
        ADDR_STATE:  reg_rdata_out <= {22'h0, cycles_q, state_q};
        default:     reg_rdata_out <= 32'h0000_0000;
      endcase
    end
    else
    begin
      reg_rdata_out <= 32'h0000_0000;
    end
  end

endmodule : cell_open_wire_diagnostic
`default_nettype wire

/* File: common/owd_pkg.sv */
// Package for the cell open wire diagnostic block
package owd_pkg;

  localparam int unsigned CH_N        = 16;
  localparam int unsigned RATIO_W     = 10;
  localparam int unsigned CNT_W       = 8;
  localparam int unsigned ADDR_W      = 4;

  // Register offsets
  localparam logic [3:0] ADDR_CTRL    = 4'h0;
  localparam logic [3:0] ADDR_PERIOD  = 4'h1;
  localparam logic [3:0] ADDR_THRESH  = 4'h2;
  localparam logic [3:0] ADDR_MAX     = 4'h3;
  localparam logic [3:0] ADDR_LOWER   = 4'h4;
  localparam logic [3:0] ADDR_UPPER   = 4'h5;
  localparam logic [3:0] ADDR_FLAGS   = 4'h6;
  localparam logic [3:0] ADDR_ISTAT   = 4'h7;
  localparam logic [3:0] ADDR_ICLR    = 4'h8;
  localparam logic [3:0] ADDR_IEN     = 4'h9;
  localparam logic [3:0] ADDR_STATE   = 4'hA;

  // Control bit positions
  localparam int unsigned CTRL_DIS_BIT = 0;

  // Interrupt status bit positions
  localparam int unsigned IRQ_SET_BIT  = 0;
  localparam int unsigned IRQ_DONE_BIT = 1;
  localparam int unsigned IRQ_W        = 2;

  // Reset values
  localparam logic        RST_DISABLE  = 1'b0;
  localparam logic [31:0] RST_PERIOD   = 32'h1575_2A00;
  localparam logic [7:0]  RST_THRESH   = 8'h03;
  localparam logic [7:0]  RST_MAX      = 8'h0A;
  localparam logic [9:0]  RST_LOWER    = 10'h320;
  localparam logic [9:0]  RST_UPPER    = 10'h3CA;
  localparam logic [9:0]  RATIO_FULL   = 10'h3E8;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01
  } scan_state_t;

  // One measurement from the front end
  typedef struct packed {
    logic [3:0]         chan;
    logic [RATIO_W-1:0] ratio;
  } sample_t;

  // Register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
    logic              wr;
    logic              rd;
  } reg_req_t;

endpackage : owd_pkg

/* File: verif/owd_chk_assertions.sv */
// Port checker for the open wire diagnostic
`timescale 1ns/1ns
`default_nettype none
module owd_chk
  import owd_pkg::*;
(
  // Watched ports
  input wire logic            clock_in,
  input wire logic            sys_rst_in,
  input wire reg_req_t        reg_req_in,
  input wire logic [31:0]     reg_rdata_out,
  input wire logic            lockout_in,
  input wire logic            contactors_closed_in,
  input wire logic            bus_connected_in,
  input wire logic            sample_valid_in,
  input wire logic [CH_N-1:0] open_wire_out,
  input wire logic            scan_active_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  wire ok_w = !lockout_in && contactors_closed_in && bus_connected_in;
  // A flag may move only after a sample or a register write
  sequence fed_s;
    $past(sample_valid_in, 2) || $past(sample_valid_in, 3) || $past(reg_req_in.wr)
      || $past(reg_req_in.wr, 2) || $past(reg_req_in.wr, 3);
  endsequence
  rd_idle_a: assert property (!$past(reg_req_in.rd) |-> reg_rdata_out == 32'h0000_0000)
    else $error("read data unasked");
  lock_stop_a: assert property (lockout_in [*6] |-> !scan_active_out)
    else $error("scan while locked");
  open_stop_a: assert property (!contactors_closed_in [*6] |-> !scan_active_out)
    else $error("scan with contactors open");
  bus_stop_a: assert property (!bus_connected_in [*6] |-> !scan_active_out)
    else $error("scan off the bus");
  start_ok_a: assert property ($rose(scan_active_out) |-> $past(ok_w, 4))
    else $error("scan started unallowed");
  flag_up_a: assert property (|(open_wire_out & ~$past(open_wire_out)) |-> fed_s)
    else $error("flag rose uncaused");
  flag_dn_a: assert property (|($past(open_wire_out) & ~open_wire_out) |-> fed_s)
    else $error("flag fell uncaused");
  one_flag_a: assert property (!$past(reg_req_in.wr) && !$past(reg_req_in.wr, 2)
    && !$past(reg_req_in.wr, 3)
    |-> $onehot0(open_wire_out ^ $past(open_wire_out))) else $error("several flags moved");
endmodule : owd_chk
bind cell_open_wire_diagnostic owd_chk owd_chk_i (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
  .reg_req_in(reg_req_in), .reg_rdata_out(reg_rdata_out), .lockout_in(lockout_in),
  .contactors_closed_in(contactors_closed_in), .bus_connected_in(bus_connected_in),
  .sample_valid_in(sample_valid_in), .open_wire_out(open_wire_out),
  .scan_active_out(scan_active_out));
`default_nettype wire

/* File: verif/fe_model.sv */
// Measurement front end model
`timescale 1ns/1ns
`default_nettype none
module fe_model
  import owd_pkg::*;
(
  // Commands
  input  wire logic    clock_in,
  input  wire logic    go_in,
  input  wire logic    done_in,
  input  wire sample_t cmd_in,
  // Toward the block
  output logic         sample_valid_out,
  output sample_t      sample_out,
  output logic         scan_done_out
);
  // Data scrambled outside valid
  always_ff @(posedge clock_in)
  begin
    sample_valid_out <= go_in;
    scan_done_out    <= done_in;
    sample_out       <= go_in ? cmd_in : ~sample_out;
  end
endmodule : fe_model
`default_nettype wire

/* File: verif/tb.sv */
// Self-checking bench for the open wire diagnostic
`timescale 1ns/1ns
`default_nettype none
module tb;
  import owd_pkg::*;
  logic            clock_in = 1'b0;
  logic            rst = 1'b1;
  reg_req_t        req = '0;
  logic [31:0]     rdata;
  logic [2:0]      blk = 3'h0;
  logic            go = 1'b0;
  logic            done = 1'b0;
  sample_t         cmd = '0;
  logic            sv;
  logic            sd;
  sample_t         smp;
  logic [CH_N-1:0] flags;
  logic            act;
  logic            irq;
  int              err_count = 0;
  int              samples_checked = 0;
  int              cyc = 0;
  always #20 clock_in = ~clock_in;
  cell_open_wire_diagnostic cell_open_wire_diagnostic_i (.clock_in(clock_in),
    .sys_rst_in(rst), .reg_req_in(req), .reg_rdata_out(rdata), .lockout_in(blk[0]),
    .contactors_closed_in(!blk[1]), .bus_connected_in(!blk[2]), .chan_installed_in(16'hFDFF),
    .meas_scan_done_in(sd), .sample_valid_in(sv), .sample_in(smp), .open_wire_out(flags),
    .scan_active_out(act), .irq_out(irq));
  fe_model fe_model_i (.clock_in(clock_in), .go_in(go), .done_in(done), .cmd_in(cmd),
    .sample_valid_out(sv), .sample_out(smp), .scan_done_out(sd));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic pause(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask : pause
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_in);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock_in);
    req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clock_in);
    req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge clock_in);
    req.rd <= 1'b0;
    #1 chk(rdata, e);
  endtask : rd
  task automatic send(input logic [3:0] ch, input logic [9:0] r, input int n);
    repeat (n)
    begin
      @(posedge clock_in);
      go  <= 1'b1;
      cmd <= '{chan: ch, ratio: r};
      @(posedge clock_in);
      go <= 1'b0;
      pause(6);
    end
  endtask : send
  task automatic wait_act(input logic v);
    int i;
    for (i = 0; i < 300 && act !== v; i++)
      @(posedge clock_in);
    #1 chk(act, v);
  endtask : wait_act
  task automatic pulse_done(input int n);
    repeat (n)
    begin
      @(posedge clock_in);
      done <= 1'b1;
      @(posedge clock_in);
      done <= 1'b0;
    end
    pause(4);
  endtask : pulse_done
  task automatic close_out();
    if (err_count == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  task automatic t_regs();
    rd(ADDR_CTRL, 32'h0000_0000);
    rd(ADDR_PERIOD, 32'h1575_2A00);
    rd(ADDR_THRESH, 32'h0000_0003);
    rd(ADDR_MAX, 32'h0000_000A);
    rd(ADDR_LOWER, 32'h0000_0320);
    rd(ADDR_UPPER, 32'h0000_03CA);
    rd(4'hF, 32'h0000_0000);
    wr(ADDR_PERIOD, 32'h0000_0032);
  endtask : t_regs
  task automatic t_low();
    wait_act(1'b1);
    send(4'h3, 10'h31F, 2);
    chk(flags, 16'h0000);
    send(4'h3, 10'h31F, 1);
    chk(flags, 16'h0008);
    chk(irq, 1'b0);
    wr(ADDR_IEN, 32'h0000_0001);
    pause(2);
    chk(irq, 1'b1);
    rd(ADDR_ISTAT, 32'h0000_0001);
    wr(ADDR_ICLR, 32'h0000_0001);
    pause(2);
    chk(irq, 1'b0);
  endtask : t_low
  task automatic t_high();
    send(4'h5, 10'h3CA, 3);
    chk(flags, 16'h0008);
    send(4'h5, 10'h3CB, 3);
    chk(flags, 16'h0028);
    send(4'h9, 10'h000, 3);
    chk(flags, 16'h0028);
    rd(ADDR_FLAGS, 32'h0000_0028);
    send(4'h3, 10'h320, 1);
    chk(flags, 16'h0020);
  endtask : t_high
  task automatic t_off();
    wr(ADDR_CTRL, 32'h0000_0001);
    pause(2);
    chk(flags, 16'h0000);
    rd(ADDR_FLAGS, 32'h0000_0000);
    wr(ADDR_CTRL, 32'h0000_0000);
    pause(2);
    chk(flags, 16'h0020);
  endtask : t_off
  task automatic t_sat();
    send(4'h5, 10'h3E8, 12);
    send(4'h5, 10'h384, 7);
    chk(flags, 16'h0020);
    send(4'h5, 10'h384, 1);
    chk(flags, 16'h0000);
  endtask : t_sat
  task automatic t_stop();
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clock_in);
      blk <= 3'h1 << i;
      wait_act(1'b0);
      @(posedge clock_in);
      blk <= 3'h0;
      pause(40);
      chk(act, 1'b0);
      wait_act(1'b1);
    end
  endtask : t_stop
  task automatic t_done();
    pulse_done(9);
    chk(act, 1'b1);
    rd(ADDR_STATE, 32'h0000_0025);
    pulse_done(1);
    wait_act(1'b0);
    rd(ADDR_ISTAT, 32'h0000_0003);
  endtask : t_done
  initial
  begin
    repeat (10) @(posedge clock_in);
    rst <= 1'b0;
    t_regs();
    t_low();
    t_high();
    t_off();
    t_sat();
    t_stop();
    t_done();
    close_out();
  end
  always @(posedge clock_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_count++;
      close_out();
    end
  end
endmodule : tb
`default_nettype wire
